// ==== logic/ble_engine.sv ====
// Blit list engine: fetches entries and runs rectangle operations
//
// What this block does
// - Fetch fixed 21-byte entries from memory
// - Optional interrupt after final entry completes
// - Source address, row step, column step
// - Destination address, row step, column step
// - Rows start at previous start plus step
// - Width nine bits, height eight bits
// - Source AND mask then XOR mask
// - Horizontal then vertical zoom replication
// - Destination steps apply per replicated output
// - Pattern repeats first bytes of source row
// - Modes zero to five byte operations
// - Mode six copies non-zero nibbles
// - Next bit chains following entry
// - Collisions off in copy mode
// - Byte collision mask groups of 32
// - Nibble collision mask groups of two
// - First collision code kept per blit
// - Mode six writes one code half
// - Stencil reads destination only with detection
// - Local memory bus only
// - Setup costs 21 memory cycles
// - Lowest priority, only granted free cycles
`timescale 1ns/1ps
module ble_engine
  import ble_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Host control
  input  wire logic [23:0] list_adr,
  input  wire logic        start,
  input  wire logic        irq_enable,
  input  wire logic        irq_clear,
  output logic             busy,
  output logic             irq,
  output logic [7:0]       collision_code,
  // Local memory port, one access per grant
  input  wire logic        mem_free,
  output logic             mem_req,
  output logic             mem_we,
  output logic [23:0]      mem_adr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_SRC   = 5'b00100,
    ST_DST   = 5'b01000,
    ST_WR    = 5'b10000
  } ble_state_t;

  ble_state_t  state;
  ble_entry_t  ent;
  logic [23:0] entry_adr;
  logic [4:0]  setup_idx;
  logic [7:0]  raw [0:ENTRY_BYTES-1];
  logic [23:0] src_row;
  logic [23:0] src_ptr;
  logic [23:0] dst_row;
  logic [23:0] dst_ptr;
  logic [8:0]  col;
  logic [7:0]  row;
  logic [2:0]  zx;
  logic [2:0]  zy;
  logic [6:0]  pat_pos;
  logic [2:0]  pat_zx;
  logic [7:0]  src_byte;
  logic [7:0]  dst_byte;
  logic        coll_seen;
  logic        have_src;

  // Grant: the engine accesses memory only on cycles others leave free
  wire logic grant = mem_req && mem_free;

  // ----------------------------------------------------------------
  // Entry decode
  // ----------------------------------------------------------------
  // field extraction
  wire ble_entry_t dec = '{
    src_adr:   {raw[2], raw[1], raw[0]},
    src_ystep: {raw[4][4:0], raw[3]},
    src_xstep: raw[OFS_SRC_XSTEP],
    dst_adr:   {raw[8], raw[7], raw[6]},
    dst_ystep: {raw[10][4:0], raw[9]},
    dst_xstep: raw[OFS_DST_XSTEP],
    width_m1:  {raw[13][0], raw[OFS_WIDTH]},
    height_m1: raw[OFS_HEIGHT],
    and_mask:  raw[OFS_AND_MASK],
    xor_mask:  raw[OFS_XOR_MASK],
    coll_mask: raw[OFS_COLL_MASK],
    zoom_x_m1: raw[OFS_ZOOM][ZOOM_X_LSB +: 3],
    zoom_y_m1: raw[OFS_ZOOM][ZOOM_Y_LSB +: 3],
    pattern_repeat_enable: raw[OFS_PATTERN][PAT_EN_BIT],
    pattern_m1: raw[OFS_PATTERN][6:0],
    // Byte 20 is still on the bus at the loading edge, not yet in raw
    next:      mem_rdata[NEXT_BIT],
    mode:      mem_rdata[2:0]
  };

  // Sign extension of steps to address width
  wire logic [23:0] sx_src  = {{16{ent.src_xstep[7]}}, ent.src_xstep};
  wire logic [23:0] sy_src  = {{11{ent.src_ystep[12]}}, ent.src_ystep};
  wire logic [23:0] sx_dst  = {{16{ent.dst_xstep[7]}}, ent.dst_xstep};
  wire logic [23:0] sy_dst  = {{11{ent.dst_ystep[12]}}, ent.dst_ystep};

  // source modification before the mode operation
  wire logic [7:0] src_mod  = (mem_rdata & ent.and_mask) ^ ent.xor_mask;

  // destination read is skipped for copy and for plain stencil
  wire logic need_dst =
    (ent.mode != MODE_COPY) &&
    !((ent.mode == MODE_STENCIL) && (ent.coll_mask == 8'h00));

  ble_combine_t cmb;
  ble_combine u_combine (
    .src       (src_byte),
    .dst       (dst_byte),
    .mode      (ent.mode),
    .coll_mask (ent.coll_mask),
    .res       (cmb)
  );

  // ----------------------------------------------------------------
  // Walk position
  // ----------------------------------------------------------------
  wire logic last_zx  = (zx == ent.zoom_x_m1);
  wire logic last_col = (col == ent.width_m1) && last_zx;
  wire logic last_zy  = (zy == ent.zoom_y_m1);
  wire logic last_row = (row == ent.height_m1) && last_zy;
  // pattern wraps after pattern_m1 + 1 source bytes, at the end of a zoom group
  wire logic pat_wrap = ent.pattern_repeat_enable && (pat_pos == ent.pattern_m1);
  wire logic src_step = last_zx;

  // Address driven for each state
  wire logic [23:0] next_mem_adr =
    (state == ST_SETUP) ? entry_adr + {19'h00000, setup_idx} :
    (state == ST_SRC)   ? src_ptr : dst_ptr;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state     <= ST_IDLE;
      busy      <= 1'b0;
      irq       <= 1'b0;
      entry_adr <= ADR_RST;
      setup_idx <= 5'h00;
      collision_code <= COLL_CODE_RST;
      coll_seen <= 1'b0;
      have_src  <= 1'b0;
      ent       <= '0;
      src_row   <= ADR_RST;
      src_ptr   <= ADR_RST;
      dst_row   <= ADR_RST;
      dst_ptr   <= ADR_RST;
      col       <= 9'h000;
      row       <= 8'h00;
      zx        <= 3'h0;
      zy        <= 3'h0;
      pat_pos   <= 7'h00;
      pat_zx    <= 3'h0;
      src_byte  <= 8'h00;
      dst_byte  <= 8'h00;
    end
    else
    begin
      if (irq_clear)
        irq <= 1'b0;
      case (state)
        ST_IDLE:
          if (start)
          begin
            entry_adr <= list_adr;
            setup_idx <= 5'h00;
            busy      <= 1'b1;
            state     <= ST_SETUP;
          end
        ST_SETUP:
          // one granted cycle per setup byte
          if (grant)
          begin
            raw[setup_idx] <= mem_rdata;
            if (setup_idx == 5'(ENTRY_BYTES - 1))
              state <= ST_SRC;
            else
              setup_idx <= setup_idx + 5'h01;
          end
        ST_SRC:
          if (grant || have_src)
          begin
            if (!have_src)
              src_byte <= src_mod;
            have_src <= 1'b1;
            state    <= need_dst ? ST_DST : ST_WR;
          end
        ST_DST:
          if (grant)
          begin
            dst_byte <= mem_rdata;
            state    <= ST_WR;
          end
        ST_WR:
          if (grant || !cmb.write)
          begin
            if (cmb.hit && !coll_seen)
            begin
              coll_seen <= 1'b1;
              if (ent.mode != MODE_NIBBLE)
                collision_code <= dst_byte;
              else if (cmb.hit_hi)
                collision_code[7:4] <= dst_byte[7:4];
              else
                collision_code[3:0] <= dst_byte[3:0];
            end
            dst_ptr <= dst_ptr + sx_dst;
            zx      <= last_zx ? 3'h0 : zx + 3'h1;
            // Zoom reuses the byte; a new column refetches
            have_src <= !src_step;
            if (src_step)
            begin
              col <= col + 9'h001;
              if (pat_wrap)
              begin
                pat_pos <= 7'h00;
                src_ptr <= src_row;
              end
              else
              begin
                pat_pos <= pat_pos + 7'h01;
                src_ptr <= src_ptr + sx_src;
              end
            end
            state <= ST_SRC;
            if (last_col)
            begin
              // rows advance from the row start
              col     <= 9'h000;
              pat_pos <= 7'h00;
              zy      <= last_zy ? 3'h0 : zy + 3'h1;
              dst_row <= dst_row + sy_dst;
              dst_ptr <= dst_row + sy_dst;
              src_row <= last_zy ? src_row + sy_src : src_row;
              src_ptr <= last_zy ? src_row + sy_src : src_row;
              if (last_zy)
                row <= row + 8'h01;
              if (last_row)
              begin
                if (ent.next)
                begin
                  entry_adr <= entry_adr + 24'(ENTRY_BYTES);
                  setup_idx <= 5'h00;
                  state     <= ST_SETUP;
                end
                else
                begin
                  busy  <= 1'b0;
                  if (irq_enable)
                    irq <= 1'b1;
                  state <= ST_IDLE;
                end
              end
            end
          end
        default:
          state <= ST_IDLE;
      endcase
      // Load walk state once the last setup byte arrives
      if (state == ST_SETUP && grant && setup_idx == 5'(ENTRY_BYTES - 1))
      begin
        ent       <= dec;
        // first access uses start addresses exactly
        src_row   <= dec.src_adr;
        src_ptr   <= dec.src_adr;
        dst_row   <= dec.dst_adr;
        dst_ptr   <= dec.dst_adr;
        col       <= 9'h000;
        row       <= 8'h00;
        zx        <= 3'h0;
        zy        <= 3'h0;
        pat_pos   <= 7'h00;
        coll_seen <= 1'b0;
        have_src  <= 1'b0;
        if (dec.mode == MODE_NIBBLE)
          collision_code <= COLL_CODE_RST;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  // request only local memory, wait for free cycle
  wire logic next_mem_req =
    (state == ST_SETUP) || (state == ST_DST) ||
    ((state == ST_SRC) && !have_src) || ((state == ST_WR) && cmb.write);

  always_comb
  begin
    mem_req   = next_mem_req;
    mem_adr   = next_mem_adr;
    mem_we    = (state == ST_WR);
    mem_wdata = cmb.result;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_busy_irq;
    @(posedge clk) disable iff (!rst_n)
    $fell(busy) |-> (irq == ($past(irq_enable) || ($past(irq) && !$past(irq_clear))));
  endproperty
  a_busy_irq: assert property (p_busy_irq) else $error("irq mismatch at list end");

  property p_no_req_idle;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE) |-> !mem_req;
  endproperty
  a_no_req_idle: assert property (p_no_req_idle) else $error("request while idle");

  property p_start_busy;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_IDLE && start) |=> busy && (state == ST_SETUP);
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");

  property p_setup_adr;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_SETUP) |-> (mem_adr == entry_adr + {19'h00000, setup_idx}) && !mem_we;
  endproperty
  a_setup_adr: assert property (p_setup_adr) else $error("setup address wrong");

  property p_setup_stall;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_SETUP && !mem_free) |=> $stable(setup_idx);
  endproperty
  a_setup_stall: assert property (p_setup_stall) else $error("setup moved without grant");

  property p_copy_no_coll;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_WR && ent.mode == MODE_COPY) |-> !cmb.hit;
  endproperty
  a_copy_no_coll: assert property (p_copy_no_coll) else $error("copy mode collided");

  property p_code_kept;
    @(posedge clk) disable iff (!rst_n)
    (coll_seen && $past(coll_seen) && state != ST_SETUP) |-> $stable(collision_code);
  endproperty
  a_code_kept: assert property (p_code_kept) else $error("collision code overwritten");

  property p_stencil_nodst;
    @(posedge clk) disable iff (!rst_n)
    (ent.mode == MODE_STENCIL && ent.coll_mask == 8'h00) |-> (state != ST_DST);
  endproperty
  a_stencil_nodst: assert property (p_stencil_nodst) else $error("needless dest read");

  property p_chain;
    @(posedge clk) disable iff (!rst_n)
    (state == ST_WR && $past(state) != ST_SETUP && grant && last_col && last_row && ent.next)
      |=> (entry_adr == $past(entry_adr) + 24'(ENTRY_BYTES));
  endproperty
  a_chain: assert property (p_chain) else $error("chain not contiguous");

endmodule : ble_engine

// ==== logic/ble_pkg.sv ====
// Shared constants and carriers for the blit list engine
package ble_pkg;

  // ----------------------------------------------------------------
  // Entry layout
  // ----------------------------------------------------------------
  localparam int unsigned ENTRY_BYTES      = 21;
  localparam logic [4:0]  OFS_SRC_ADR      = 5'h00;
  localparam logic [4:0]  OFS_SRC_YSTEP    = 5'h03;
  localparam logic [4:0]  OFS_SRC_XSTEP    = 5'h05;
  localparam logic [4:0]  OFS_DST_ADR      = 5'h06;
  localparam logic [4:0]  OFS_DST_YSTEP    = 5'h09;
  localparam logic [4:0]  OFS_DST_XSTEP    = 5'h0B;
  localparam logic [4:0]  OFS_WIDTH        = 5'h0C;
  localparam logic [4:0]  OFS_HEIGHT       = 5'h0E;
  localparam logic [4:0]  OFS_AND_MASK     = 5'h0F;
  localparam logic [4:0]  OFS_XOR_MASK     = 5'h10;
  localparam logic [4:0]  OFS_COLL_MASK    = 5'h11;
  localparam logic [4:0]  OFS_ZOOM         = 5'h12;
  localparam logic [4:0]  OFS_PATTERN      = 5'h13;
  localparam logic [4:0]  OFS_MODE         = 5'h14;
  localparam int unsigned ZOOM_X_LSB       = 0;
  localparam int unsigned ZOOM_Y_LSB       = 4;
  localparam int unsigned PAT_EN_BIT       = 7;
  localparam int unsigned NEXT_BIT         = 3;

  // ----------------------------------------------------------------
  // Modes and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  MODE_COPY        = 3'h0;
  localparam logic [2:0]  MODE_STENCIL     = 3'h1;
  localparam logic [2:0]  MODE_ADD         = 3'h2;
  localparam logic [2:0]  MODE_OR          = 3'h3;
  localparam logic [2:0]  MODE_AND         = 3'h4;
  localparam logic [2:0]  MODE_XOR         = 3'h5;
  localparam logic [2:0]  MODE_NIBBLE      = 3'h6;
  localparam logic [7:0]  COLL_CODE_RST    = 8'h00;
  localparam logic [23:0] ADR_RST          = 24'h000000;

  // One decoded entry
  typedef struct packed {
    logic [23:0] src_adr;
    logic [12:0] src_ystep;
    logic [7:0]  src_xstep;
    logic [23:0] dst_adr;
    logic [12:0] dst_ystep;
    logic [7:0]  dst_xstep;
    logic [8:0]  width_m1;
    logic [7:0]  height_m1;
    logic [7:0]  and_mask;
    logic [7:0]  xor_mask;
    logic [7:0]  coll_mask;
    logic [2:0]  zoom_x_m1;
    logic [2:0]  zoom_y_m1;
    logic        pattern_repeat_enable;
    logic [6:0]  pattern_m1;
    logic        next;
    logic [2:0]  mode;
  } ble_entry_t;

  // Result of one combine step
  typedef struct packed {
    logic [7:0] result;
    logic       write;
    logic       hit;
    logic       hit_hi;
  } ble_combine_t;

endpackage : ble_pkg

// ==== logic/ble_combine.sv ====
// Combine unit: mode operation and collision test for one byte
`timescale 1ns/1ps
module ble_combine
  import ble_pkg::*;
(
  // Operands
  input  wire logic [7:0]   src,
  input  wire logic [7:0]   dst,
  input  wire logic [2:0]   mode,
  input  wire logic [7:0]   coll_mask,
  // Result
  output ble_pkg::ble_combine_t res
);
  wire logic src_hi_nz = (src[7:4] != 4'h0);
  wire logic src_lo_nz = (src[3:0] != 4'h0);
  wire logic dst_hi_nz = (dst[7:4] != 4'h0);
  wire logic dst_lo_nz = (dst[3:0] != 4'h0);
  // byte groups of 32, nibble groups of two
  wire logic byte_en   = coll_mask[dst[7:5]] && (dst != 8'h00);
  wire logic hi_en     = coll_mask[dst[7:5]] && dst_hi_nz;
  wire logic lo_en     = coll_mask[dst[3:1]] && dst_lo_nz;
  wire logic src_nz    = (src != 8'h00);

  always_comb
  begin
    res = '0;
    case (mode)
      MODE_COPY:    res = '{src, 1'b1, 1'b0, 1'b0};
      MODE_STENCIL: res = '{src, src_nz, src_nz && byte_en, 1'b0};
      MODE_ADD:     res = '{src + dst, 1'b1, src_nz && byte_en, 1'b0};
      MODE_OR:      res = '{src | dst, 1'b1, src_nz && byte_en, 1'b0};
      MODE_AND:     res = '{src & dst, 1'b1, src_nz && byte_en, 1'b0};
      MODE_XOR:     res = '{src ^ dst, 1'b1, src_nz && byte_en, 1'b0};
      MODE_NIBBLE:
      begin
        res.result = {src_hi_nz ? src[7:4] : dst[7:4], src_lo_nz ? src[3:0] : dst[3:0]};
        res.write  = 1'b1;
        res.hit_hi = src_hi_nz && hi_en;
        res.hit    = res.hit_hi || (src_lo_nz && lo_en);
      end
      default:      res = '{dst, 1'b0, 1'b0, 1'b0};
    endcase
  end

endmodule : ble_combine

// ==== sim/ble_mem_model.sv ====
// Local video memory model with a paced grant, partner of the blit engine
`timescale 1ns/1ps
module ble_mem_model (
  // Clock and grant pace
  input  wire logic        clk,
  input  wire logic        slow,
  // Engine side
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [23:0] mem_adr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_free,
  output logic [7:0]       mem_rdata,
  // Access counters
  output int               n_rd,
  output int               n_wr
);
  logic [7:0] ram [0:65535];
  logic [7:0] last = 8'h00;
  logic [1:0] phase = 2'h0;
  logic       rd_now;
  logic       wr_now;

  // ----------------------------------------------------------------
  // Grants and data
  // ----------------------------------------------------------------
  // lowest priority grants
  // Slow pace hands two of three cycles to other requesters
  assign mem_free  = !slow || (phase == 2'h0);
  assign rd_now    = mem_req && mem_free && !mem_we;
  assign wr_now    = mem_req && mem_free && mem_we;
  // local memory only
  // Outside a granted read the bus shows the inverse of the last value
  assign mem_rdata = rd_now ? ram[mem_adr[15:0]] : ~last;

  always @(posedge clk)
  begin
    phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    if (rd_now)
    begin
      last <= ram[mem_adr[15:0]];
      n_rd <= n_rd + 1;
    end
    if (wr_now)
    begin
      ram[mem_adr[15:0]] <= mem_wdata;
      n_wr <= n_wr + 1;
    end
  end
endmodule : ble_mem_model

// ==== sim/testbench.sv ====
// Self-checking bench for the blit list engine
`timescale 1ns/1ps
module testbench;
  import ble_pkg::*;

  logic        clk;
  logic        rst_n;
  logic [23:0] list_adr;
  logic        start;
  logic        irq_enable;
  logic        irq_clear;
  logic        slow;
  logic        busy;
  logic        irq;
  logic [7:0]  collision_code;
  logic        mem_free;
  logic        mem_req;
  logic        mem_we;
  logic [23:0] mem_adr;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem_rdata;
  int          n_rd;
  int          n_wr;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          exp_rd;
  int          exp_wr;
  logic [7:0]  exp_code;
  logic [7:0]  sh [0:65535];
  ble_entry_t  q [$];

  ble_engine dut_u (.clk(clk), .rst_n(rst_n), .list_adr(list_adr), .start(start),
    .irq_enable(irq_enable), .irq_clear(irq_clear), .busy(busy), .irq(irq),
    .collision_code(collision_code), .mem_free(mem_free), .mem_req(mem_req),
    .mem_we(mem_we), .mem_adr(mem_adr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  ble_mem_model mem_u (.clk(clk), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
    .mem_adr(mem_adr), .mem_wdata(mem_wdata), .mem_free(mem_free), .mem_rdata(mem_rdata),
    .n_rd(n_rd), .n_wr(n_wr));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard, well above the longest list in this run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      error_cnt++;
      $display("BAD t=%0t run did not finish", $time);
      wrap_up();
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk_int(input int got, input int exp, input string what);
    n_checks++;
    if (got != exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_int

  // Reports the first differing address, -1 when the images agree
  task automatic chk_mem(input string what);
    int at;
    at = -1;
    for (int a = 0; a < 65536; a++)
      if (mem_u.ram[a] !== sh[a] && at < 0)
        at = a;
    chk_int(at, -1, what);
  endtask : chk_mem

  // ----------------------------------------------------------------
  // Entry image and reference blit
  // ----------------------------------------------------------------
  // entry byte layout
  task automatic put_entry(input logic [23:0] a, input ble_entry_t e);
    logic [7:0] b [21];
    b = '{e.src_adr[7:0], e.src_adr[15:8], e.src_adr[23:16], e.src_ystep[7:0],
          {3'h0, e.src_ystep[12:8]}, e.src_xstep, e.dst_adr[7:0], e.dst_adr[15:8],
          e.dst_adr[23:16], e.dst_ystep[7:0], {3'h0, e.dst_ystep[12:8]}, e.dst_xstep,
          e.width_m1[7:0], {7'h0, e.width_m1[8]}, e.height_m1, e.and_mask, e.xor_mask,
          e.coll_mask, {1'b0, e.zoom_y_m1, 1'b0, e.zoom_x_m1},
          {e.pattern_repeat_enable, e.pattern_m1}, {4'h0, e.next, e.mode}};
    for (int i = 0; i < 21; i++)
    begin
      mem_u.ram[a[15:0] + 16'(i)] = b[i];
      sh[a[15:0] + 16'(i)] = b[i];
    end
  endtask : put_entry

  task automatic ref_blit(input ble_entry_t e);
    logic [23:0] sr, dr, da, sys, sxs, dys, dxs;
    logic [7:0]  s, d, r;
    logic        hi, lo, seen;
    int          sx;
    sys = {{11{e.src_ystep[12]}}, e.src_ystep};
    sxs = {{16{e.src_xstep[7]}}, e.src_xstep};
    dys = {{11{e.dst_ystep[12]}}, e.dst_ystep};
    dxs = {{16{e.dst_xstep[7]}}, e.dst_xstep};
    sr = e.src_adr;
    dr = e.dst_adr;
    seen = 1'b0;
    exp_rd += 21;
    if (e.mode == MODE_NIBBLE)
      exp_code = 8'h00;
    for (int y = 0; y <= e.height_m1; y++)
    begin
      for (int zy = 0; zy <= e.zoom_y_m1; zy++)
      begin
        da = dr;
        for (int c = 0; c <= e.width_m1; c++)
        begin
          sx = e.pattern_repeat_enable ? c % (e.pattern_m1 + 1) : c;
          s = (sh[16'(sr + 24'(sx) * sxs)] & e.and_mask) ^ e.xor_mask;
          exp_rd++;
          for (int zx = 0; zx <= e.zoom_x_m1; zx++)
          begin
            d = sh[da[15:0]];
            if (e.mode != MODE_COPY && !(e.mode == MODE_STENCIL && e.coll_mask == 8'h00))
              exp_rd++;
            case (e.mode)
              MODE_STENCIL: r = (s != 8'h00) ? s : d;
              MODE_ADD:     r = d + s;
              MODE_OR:      r = d | s;
              MODE_AND:     r = d & s;
              MODE_XOR:     r = d ^ s;
              MODE_NIBBLE:  r = {(s[7:4] != 4'h0) ? s[7:4] : d[7:4],
                                 (s[3:0] != 4'h0) ? s[3:0] : d[3:0]};
              default:      r = s;
            endcase
            hi = s[7:4] != 4'h0 && d[7:4] != 4'h0 && e.coll_mask[d[7:5]];
            lo = s[3:0] != 4'h0 && d[3:0] != 4'h0 && e.coll_mask[d[3:1]];
            if (e.mode != MODE_NIBBLE)
              hi = e.mode != MODE_COPY && s != 8'h00 && d != 8'h00 && e.coll_mask[d[7:5]];
            if (!seen && (hi || (lo && e.mode == MODE_NIBBLE)))
            begin
              seen = 1'b1;
              if (e.mode != MODE_NIBBLE)
                exp_code = d;
              else
                exp_code = hi ? {d[7:4], exp_code[3:0]} : {exp_code[7:4], d[3:0]};
            end
            if (!(e.mode == MODE_STENCIL && s == 8'h00))
            begin
              sh[da[15:0]] = r;
              exp_wr++;
            end
            da = da + dxs;
          end
        end
        dr = dr + dys;
      end
      sr = sr + sys;
    end
  endtask : ref_blit

  // ----------------------------------------------------------------
  // One list run with all its checks
  // ----------------------------------------------------------------
  task automatic do_list(input logic [23:0] la, input logic ien, input logic pace,
                         input string name);
    logic [23:0] a;
    int          rd0, wr0, t;
    a = la;
    exp_rd = 0;
    exp_wr = 0;
    foreach (q[i])
    begin
      q[i].next = (i < q.size() - 1);
      put_entry(a, q[i]);
      a = a + 24'd21;
    end
    foreach (q[i])
      ref_blit(q[i]);
    rd0 = n_rd;
    wr0 = n_wr;
    @(posedge clk);
    slow <= pace;
    list_adr <= la;
    irq_enable <= ien;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    list_adr <= 24'h00F000;
    #1;
    chk8({7'h0, busy}, 8'h01, "busy after start");
    repeat (5) @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    t = 0;
    while (busy !== 1'b0 && t < 20000)
    begin
      @(posedge clk);
      #1;
      t++;
    end
    @(posedge clk);
    #1;
    chk8({7'h0, busy}, 8'h00, "busy at end");
    chk8({7'h0, irq}, {7'h0, ien}, "irq at end");
    chk8(collision_code, exp_code, "collision code");
    chk_int(n_rd - rd0, exp_rd, "read count");
    chk_int(n_wr - wr0, exp_wr, "write count");
    chk_mem("memory image");
    @(posedge clk);
    irq_clear <= 1'b1;
    @(posedge clk);
    irq_clear <= 1'b0;
    #1;
    chk8({7'h0, irq}, 8'h00, "irq cleared");
    q.delete();
    $display("test %s done, mismatches so far %0d", name, error_cnt);
  endtask : do_list

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Fields: src, src_ystep, src_xstep, dst, dst_ystep, dst_xstep, width_m1,
  // height_m1, and, xor, coll, zoom_x_m1, zoom_y_m1, pattern en, pattern_m1, next, mode
  initial
  begin
    rst_n = 1'b0;
    start = 1'b0;
    list_adr = 24'h000000;
    irq_enable = 1'b0;
    irq_clear = 1'b0;
    slow = 1'b0;
    exp_code = COLL_CODE_RST;
    for (int a = 0; a < 65536; a++)
    begin
      mem_u.ram[a] = 8'(a * 7 + a / 256);
      sh[a] = 8'(a * 7 + a / 256);
    end
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk8({6'h0, busy, irq}, 8'h00, "busy and irq in reset");
    chk8({7'h0, mem_req}, 8'h00, "no request in reset");
    chk8(collision_code, COLL_CODE_RST, "code in reset");
    q.push_back('{24'h001000, 13'h0010, 8'h01, 24'h002080, 13'h1FF0, 8'hFF, 9'h002, 8'h01,
                  8'hF7, 8'h21, 8'hFF, 3'h1, 3'h2, 1'b0, 7'h00, 1'b0, MODE_COPY});
    q.push_back('{24'h001080, 13'h0000, 8'h01, 24'h002400, 13'h0020, 8'h01, 9'h000, 8'h00,
                  8'hFF, 8'h00, 8'hFF, 3'h7, 3'h7, 1'b0, 7'h00, 1'b0, MODE_XOR});
    do_list(24'h000100, 1'b1, 1'b0, "copy and xor zoom");
    q.push_back('{24'h001100, 13'h0000, 8'h01, 24'h003000, 13'h0000, 8'h01, 9'h100, 8'h00,
                  8'hFF, 8'h00, 8'h80, 3'h0, 3'h0, 1'b0, 7'h00, 1'b0, MODE_ADD});
    q.push_back('{24'h001200, 13'h0040, 8'h01, 24'h003400, 13'h0040, 8'h01, 9'h007, 8'h01,
                  8'hFF, 8'h00, 8'h00, 3'h1, 3'h0, 1'b1, 7'h02, 1'b0, MODE_OR});
    q.push_back('{24'h001400, 13'h1FC0, 8'h00, 24'h003800, 13'h0020, 8'h01, 9'h003, 8'h02,
                  8'hFF, 8'h00, 8'h0F, 3'h0, 3'h0, 1'b0, 7'h00, 1'b0, MODE_AND});
    do_list(24'h000200, 1'b0, 1'b1, "add or and chain");
    q.push_back('{24'h001500, 13'h0010, 8'h01, 24'h004000, 13'h0020, 8'h01, 9'h00F, 8'h03,
                  8'h03, 8'h00, 8'h00, 3'h0, 3'h0, 1'b0, 7'h00, 1'b0, MODE_STENCIL});
    q.push_back('{24'h001600, 13'h0010, 8'h01, 24'h004400, 13'h0020, 8'h01, 9'h00F, 8'h03,
                  8'h81, 8'h00, 8'h05, 3'h0, 3'h0, 1'b0, 7'h00, 1'b0, MODE_STENCIL});
    do_list(24'h000300, 1'b1, 1'b0, "stencil");
    q.push_back('{24'h001700, 13'h0010, 8'h01, 24'h004800, 13'h0020, 8'h01, 9'h00F, 8'h03,
                  8'h3C, 8'h00, 8'hFF, 3'h0, 3'h0, 1'b0, 7'h00, 1'b0, MODE_NIBBLE});
    q.push_back('{24'h001800, 13'h0010, 8'h01, 24'h004C00, 13'h0020, 8'h01, 9'h00F, 8'h03,
                  8'hFF, 8'h00, 8'hFF, 3'h0, 3'h0, 1'b0, 7'h00, 1'b0, MODE_COPY});
    do_list(24'h000400, 1'b1, 1'b1, "nibble then copy");
    wrap_up();
  end
endmodule : testbench
